/* File: design/flash_guard_map.svh */
// offsets, field positions, reset values and timing counts of the sector guard block
`ifndef FLASH_GUARD_MAP_SVH
`define FLASH_GUARD_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define REG_VCW 8'h00
`define REG_PCW 8'h04
`define REG_PW_LO 8'h08
`define REG_PW_HI 8'h0c
`define REG_STATUS 8'h10
`define REG_NV_GUARD 8'h14
`define REG_VOL_GUARD 8'h18
`define REG_OTP_ADDR 8'h1c
`define REG_OTP_DATA 8'h20

// ==========================================================
// fields
`define VCW_FREEZE_BIT 10
`define PCW_MODE_MSB 2
`define PCW_MODE_LSB 1
`define MODE_TEMP 2'b11
`define MODE_PERS 2'b10
`define MODE_PASS 2'b01
`define MODE_NONE 2'b00
`define ST_PFAIL_BIT 1
`define ST_EFAIL_BIT 2
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ==========================================================
// reset values
`define VCW_RESET 16'hffff
`define PCW_RESET 16'hffff
`define PW_RESET 64'hffff_ffff_ffff_ffff
`define GUARD_RESET 16'hffff
`define LINK_IDLE 11'h600
// factory random number, value arbitrary
`define OTP_RANDOM 128'h5a3c_96e1_0f87_2d4b_c3a5_7e19_b26d_48f0

// ==========================================================
// secure area geometry (16-bit words) and sector count
`define OTP_WORDS 512
`define OTP_AW 9
`define OTP_RAND_WORDS 9'h008
`define OTP_LOCK_WORD 9'h008
`define SECTORS 16

// ==========================================================
// link command codes
`define CMD_OTP_ENTER 8'h01
`define CMD_GUARD_ENTER 8'h02
`define CMD_OVL_EXIT 8'h03
`define CMD_PROGRAM 8'h04
`define CMD_NV_PROGRAM 8'h05
`define CMD_NV_ERASE 8'h06
`define CMD_NV_READ 8'h07
`define CMD_VOL_SET 8'h08
`define CMD_VOL_CLEAR 8'h09
`define CMD_LOCK_CLEAR 8'h0a
`define CMD_PW_UNLOCK 8'h0b
`define CMD_SOFT_RESET 8'h0c

// ==========================================================
// timing
`define CLK_PERIOD_NS 4
`define PROG_TIME_NS 1000
`define ERASE_TIME_NS 4000
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYCLES ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: design/flash_guard_pkg.sv */
// types of the sector guard block
`include "flash_guard_map.svh"
package flash_guard_pkg;
	typedef enum logic [1:0] {OVL_ARRAY, OVL_OTP, OVL_GUARD} overlay_t;
	typedef enum logic [2:0] {
		OP_IDLE, OP_OTP_PROG, OP_NV_PROG, OP_NV_PREPROG, OP_NV_ERASE, OP_FAIL_P, OP_FAIL_E
	} op_t;
	typedef struct packed {
		logic [10:0] sync1;
		logic [10:0] sync2;
		logic [10:0] sync3;
		logic [10:0] filt;
		logic [3:0] nbytes;
		logic [7:0] cmd;
		logic [63:0] payload;
		overlay_t ovl;
		op_t op;
		logic [15:0] cnt;
		logic [`OTP_AW-1:0] op_addr;
		logic [15:0] op_data;
		logic [3:0] op_sector;
		logic lock;
		logic pfail;
		logic efail;
		logic guard_rd;
		logic allow;
		logic [15:0] vcw;
		logic [15:0] pcw;
		logic [`SECTORS-1:0] nv;
		logic [`SECTORS-1:0] vol;
		logic [63:0] pw;
		logic [`OTP_WORDS-1:0][15:0] otp;
		logic [`OTP_AW-1:0] otp_raddr;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;
endpackage

/* File: design/flash_sector_protection.sv */
// secure area and sector guard logic with an AXI4-Lite register slave
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "flash_guard_map.svh"
module flash_sector_protection (
	// clock and power-on reset
	input wire logic clock_in,
	input wire logic reset_n_in,
	// axi4-lite write
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [7:0] awaddr_in,
	input wire logic wvalid_in,
	output logic wready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	output logic bvalid_out,
	input wire logic bready_in,
	output logic [1:0] bresp_out,
	// axi4-lite read
	input wire logic arvalid_in,
	output logic arready_out,
	input wire logic [7:0] araddr_in,
	output logic rvalid_out,
	input wire logic rready_in,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	// command link and hardware reset pin
	input wire logic link_clock_in,
	input wire logic link_select_n_in,
	input wire logic [7:0] link_data_in,
	input wire logic hard_reset_n_in,
	// array write permission
	input wire logic [3:0] array_sector_in,
	output logic array_write_allowed_out
);
	flash_guard_pkg::state_t q;
	flash_guard_pkg::state_t d;
	logic [10:0] agree;
	logic lk_edge;
	logic frame_end;
	logic exec_cmd;
	logic hw_evt;
	logic [31:0] wval;
	logic [3:0] sec;
	logic [`OTP_AW-1:0] oaddr;
	logic [15:0] odata;
	logic [31:0] lock_bits;

	// ==========================================================
	// helpers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a == `REG_VCW || a == `REG_PCW || a == `REG_PW_LO || a == `REG_PW_HI ||
			a == `REG_STATUS || a == `REG_NV_GUARD || a == `REG_VOL_GUARD ||
			a == `REG_OTP_ADDR || a == `REG_OTP_DATA;
	endfunction

	function automatic logic [31:0] rd_word(input flash_guard_pkg::state_t s, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			`REG_VCW: r = {16'h0000, s.vcw};
			`REG_PCW: r = {16'h0000, s.pcw};
			`REG_STATUS: r = {25'h0000000, s.guard_rd, s.ovl, s.lock, s.efail, s.pfail,
				s.op != flash_guard_pkg::OP_IDLE};
			`REG_NV_GUARD: r = {16'h0000, s.nv};
			`REG_VOL_GUARD: r = {16'h0000, s.vol};
			`REG_OTP_ADDR: r = {23'h000000, s.otp_raddr};
			`REG_OTP_DATA: r = {16'h0000, s.otp[s.otp_raddr]};
			default: r = 32'h0000_0000; // password words read as zero: hidden
		endcase
		return r;
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		d = q;
		wval = merge(32'h0000_0000, q.w_data, q.w_strb);
		// three-stage pin sampling, a bit counts when stages two and three agree
		d.sync1 = {hard_reset_n_in, link_select_n_in, link_data_in, link_clock_in};
		d.sync2 = q.sync1;
		d.sync3 = q.sync2;
		agree = ~(q.sync2 ^ q.sync3);
		d.filt = (q.sync2 & agree) | (q.filt & ~agree);
		lk_edge = d.filt[0] & ~q.filt[0];
		frame_end = d.filt[9] & ~q.filt[9];
		hw_evt = ~d.filt[10] & q.filt[10];
		sec = q.payload[3:0];
		oaddr = q.payload[16 +: `OTP_AW];
		odata = q.payload[15:0];
		lock_bits = {q.otp[`OTP_LOCK_WORD + 9'h001], q.otp[`OTP_LOCK_WORD]};
		exec_cmd = 1'b0;

		// axi write side: address and data taken in either order
		if (awvalid_in && awready_out) begin
			d.aw_got = 1'b1;
			d.aw_addr = awaddr_in;
		end
		if (wvalid_in && wready_out) begin
			d.w_got = 1'b1;
			d.w_data = wdata_in;
			d.w_strb = wstrb_in;
		end
		if (q.bvalid && bready_in) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_got && q.w_got) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = mapped(q.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
			unique case (q.aw_addr)
				`REG_VCW: d.vcw = (q.vcw & ~{{8{q.w_strb[1]}}, {8{q.w_strb[0]}}}) | wval[15:0];
				`REG_PCW: begin
					// one-time bits only fall, and only while the method is still open
					if (q.pcw[`PCW_MODE_MSB:`PCW_MODE_LSB] == `MODE_TEMP &&
						(q.pcw[`PCW_MODE_MSB:`PCW_MODE_LSB] &
						wval[`PCW_MODE_MSB:`PCW_MODE_LSB]) != `MODE_NONE) begin
						d.pcw = q.pcw & (wval[15:0] | ~{{8{q.w_strb[1]}}, {8{q.w_strb[0]}}});
					end
				end
				`REG_PW_LO: begin
					if (q.pcw[`PCW_MODE_MSB:`PCW_MODE_LSB] == `MODE_TEMP) begin
						d.pw[31:0] = merge(q.pw[31:0], q.w_data, q.w_strb);
					end
				end
				`REG_PW_HI: begin
					if (q.pcw[`PCW_MODE_MSB:`PCW_MODE_LSB] == `MODE_TEMP) begin
						d.pw[63:32] = merge(q.pw[63:32], q.w_data, q.w_strb);
					end
				end
				`REG_STATUS: begin
					// write one to clear; a failure landing later this cycle still wins
					if (wval[`ST_PFAIL_BIT]) begin
						d.pfail = 1'b0;
					end
					if (wval[`ST_EFAIL_BIT]) begin
						d.efail = 1'b0;
					end
				end
				`REG_OTP_ADDR: d.otp_raddr = wval[`OTP_AW-1:0];
				default: begin
				end
			endcase
		end

		// axi read side, status always answers even while busy
		if (q.rvalid && rready_in) begin
			d.rvalid = 1'b0;
		end
		if (arvalid_in && arready_out) begin
			d.rvalid = 1'b1;
			d.rdata = rd_word(q, araddr_in);
			d.rresp = mapped(araddr_in) ? `RESP_OKAY : `RESP_SLVERR;
		end

		// link framing: first byte is the command, later bytes shift into payload
		if (lk_edge && !d.filt[9]) begin
			if (q.nbytes == 4'h0) begin
				d.cmd = d.filt[8:1];
			end else begin
				d.payload = {q.payload[55:0], d.filt[8:1]};
			end
			if (q.nbytes != 4'hf) begin
				d.nbytes = q.nbytes + 4'h1;
			end
		end
		if (frame_end) begin
			d.nbytes = 4'h0;
			// frames arriving while an algorithm runs are dropped
			exec_cmd = q.nbytes != 4'h0 && q.op == flash_guard_pkg::OP_IDLE && q.filt[10];
		end

		if (exec_cmd) begin
			unique case (q.cmd)
				`CMD_OTP_ENTER: d.ovl = flash_guard_pkg::OVL_OTP;
				`CMD_GUARD_ENTER: d.ovl = flash_guard_pkg::OVL_GUARD;
				`CMD_OVL_EXIT: d.ovl = flash_guard_pkg::OVL_ARRAY;
				`CMD_PROGRAM: begin
					// sector guard mode plays no part here, only freeze and the secure area lock word do
					if (q.ovl == flash_guard_pkg::OVL_OTP && q.vcw[`VCW_FREEZE_BIT]) begin
						if (!lock_bits[oaddr[`OTP_AW-1:4]] ||
							(oaddr < `OTP_RAND_WORDS && (q.otp[oaddr] & ~odata) != 16'h0000)) begin
							d.pfail = 1'b1;
						end else begin
							d.op = flash_guard_pkg::OP_OTP_PROG;
							d.cnt = 16'(`PROG_CYCLES);
							d.op_addr = oaddr;
							d.op_data = odata;
						end
					end
				end
				`CMD_NV_PROGRAM: begin
					if (q.ovl == flash_guard_pkg::OVL_GUARD) begin
						d.op = q.lock ? flash_guard_pkg::OP_NV_PROG : flash_guard_pkg::OP_FAIL_P;
						d.cnt = 16'(`PROG_CYCLES);
						d.op_sector = sec;
					end
				end
				`CMD_NV_ERASE: begin
					if (q.ovl == flash_guard_pkg::OVL_GUARD) begin
						d.op = q.lock ? flash_guard_pkg::OP_NV_PREPROG : flash_guard_pkg::OP_FAIL_E;
						d.cnt = 16'(`PROG_CYCLES);
					end
				end
				`CMD_NV_READ: begin
					if (q.ovl == flash_guard_pkg::OVL_GUARD) begin
						d.guard_rd = q.nv[sec];
					end
				end
				`CMD_VOL_SET: d.vol[sec] = 1'b0;
				`CMD_VOL_CLEAR: d.vol[sec] = 1'b1;
				`CMD_LOCK_CLEAR: d.lock = 1'b0;
				`CMD_PW_UNLOCK: begin
					if (q.pcw[`PCW_MODE_MSB:`PCW_MODE_LSB] == `MODE_PASS && q.payload == q.pw) begin
						d.lock = 1'b1;
					end
				end
				`CMD_SOFT_RESET: begin
					d.ovl = flash_guard_pkg::OVL_ARRAY;
					d.pfail = 1'b0;
					d.efail = 1'b0;
				end
				default: begin
				end
			endcase
		end

		// embedded algorithm; the secure area has no erase at all
		if (q.op != flash_guard_pkg::OP_IDLE) begin
			d.cnt = q.cnt - 16'h0001;
			if (q.cnt == 16'h0001) begin
				d.op = flash_guard_pkg::OP_IDLE;
				unique case (q.op)
					flash_guard_pkg::OP_OTP_PROG: d.otp[q.op_addr] = q.otp[q.op_addr] & q.op_data;
					flash_guard_pkg::OP_NV_PROG: d.nv[q.op_sector] = 1'b0;
					flash_guard_pkg::OP_NV_PREPROG: begin
						d.nv = '0;
						d.op = flash_guard_pkg::OP_NV_ERASE;
						d.cnt = 16'(`ERASE_CYCLES);
					end
					flash_guard_pkg::OP_NV_ERASE: d.nv = `GUARD_RESET;
					flash_guard_pkg::OP_FAIL_P: d.pfail = 1'b1;
					flash_guard_pkg::OP_FAIL_E: d.efail = 1'b1;
					default: begin
					end
				endcase
			end
		end

		// hardware reset pin: volatile state back to defaults
		if (hw_evt) begin
			d.lock = q.pcw[`PCW_MODE_MSB:`PCW_MODE_LSB] != `MODE_PASS;
			d.vol = `GUARD_RESET;
			d.vcw = `VCW_RESET;
			d.ovl = flash_guard_pkg::OVL_ARRAY;
			d.op = flash_guard_pkg::OP_IDLE;
			d.pfail = 1'b0;
			d.efail = 1'b0;
		end
		d.allow = q.nv[array_sector_in] & q.vol[array_sector_in];
	end

	// ==========================================================
	// state register
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			q <= '0;
			q.sync1 <= `LINK_IDLE;
			q.sync2 <= `LINK_IDLE;
			q.sync3 <= `LINK_IDLE;
			q.filt <= `LINK_IDLE;
			q.lock <= 1'b1;
			q.vcw <= `VCW_RESET;
			q.pcw <= `PCW_RESET;
			q.pw <= `PW_RESET;
			q.nv <= `GUARD_RESET;
			q.vol <= `GUARD_RESET;
			q.allow <= 1'b1;
			q.otp <= {{(`OTP_WORDS - 8){16'hffff}}, `OTP_RANDOM};
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs
	assign awready_out = !q.aw_got && !q.bvalid;
	assign wready_out = !q.w_got && !q.bvalid;
	assign bvalid_out = q.bvalid;
	assign bresp_out = q.bresp;
	assign arready_out = !q.rvalid;
	assign rvalid_out = q.rvalid;
	assign rdata_out = q.rdata;
	assign rresp_out = q.rresp;
	assign array_write_allowed_out = q.allow;

	// ==========================================================
	// checks
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	a_lock_clear_takes: assert property (
		exec_cmd && q.cmd == `CMD_LOCK_CLEAR && !hw_evt |=> !q.lock)
		else $error("lock clear did not clear the lock");
	a_no_soft_set: assert property (q.pcw[2:1] != `MODE_PASS && !q.lock && !hw_evt |=> !q.lock)
		else $error("lock set without hardware reset");
	a_hw_lock_pass: assert property (hw_evt && q.pcw[2:1] == `MODE_PASS |=> !q.lock)
		else $error("password mode reset left lock set");
	a_hw_lock_pers: assert property (hw_evt && q.pcw[2:1] != `MODE_PASS |=> q.lock)
		else $error("persistent mode reset left lock clear");
	a_locked_abort: assert property (exec_cmd && q.cmd == `CMD_NV_PROGRAM &&
		!q.lock && !hw_evt && q.ovl == flash_guard_pkg::OVL_GUARD |=>
		q.op == flash_guard_pkg::OP_FAIL_P)
		else $error("locked guard program not aborted");
	a_abort_stable: assert property (q.op == flash_guard_pkg::OP_FAIL_P ||
		q.op == flash_guard_pkg::OP_FAIL_E |=> $stable(q.nv))
		else $error("aborted operation changed guard bits");
	a_freeze_silent: assert property (exec_cmd && q.cmd == `CMD_PROGRAM && !q.vcw[10] &&
		!hw_evt |=> q.op == flash_guard_pkg::OP_IDLE && $stable(q.pfail) && $stable(q.otp))
		else $error("frozen secure program had an effect");
	a_otp_overlay: assert property (exec_cmd && q.cmd == `CMD_PROGRAM &&
		q.ovl != flash_guard_pkg::OVL_OTP |=> q.op == flash_guard_pkg::OP_IDLE)
		else $error("secure program outside overlay");
	a_exit_overlay: assert property (exec_cmd && q.cmd == `CMD_OVL_EXIT |=>
		q.ovl == flash_guard_pkg::OVL_ARRAY)
		else $error("overlay exit ignored");
	a_write_allowed: assert property (##1 array_write_allowed_out ==
		($past(q.nv[array_sector_in]) && $past(q.vol[array_sector_in])))
		else $error("write permission disagrees with guard bits");
	a_prog_time: assert property ($rose(q.op == flash_guard_pkg::OP_NV_PROG) |->
		(q.op == flash_guard_pkg::OP_NV_PROG)[*8])
		else $error("guard program ended too early");

	c_unlock: cover property (exec_cmd && q.cmd == `CMD_PW_UNLOCK ##1 q.lock);
	c_erase: cover property (q.op == flash_guard_pkg::OP_NV_ERASE ##1
		q.op == flash_guard_pkg::OP_IDLE);
	c_otp_prog: cover property (q.op == flash_guard_pkg::OP_OTP_PROG ##1
		q.op == flash_guard_pkg::OP_IDLE);
endmodule // flash_sector_protection

/* File: sim/link_host_model.sv */
// host side model of the command link
`timescale 1ns/1ps
module link_host_model (
	// link pins
	output logic link_clock_out,
	output logic link_select_n_out,
	output logic [7:0] link_data_out
);
	// ==========================================
	// idle levels
	initial begin
		link_clock_out = 1'b0;
		link_select_n_out = 1'b1;
		link_data_out = 8'h00;
	end
	// ==========================================
	// frame sender
	// clock stands still between frames; released data inverts so stale bytes never match
	task automatic send(input logic [7:0] cmd, input logic [63:0] pl, input int n);
		#1 link_select_n_out = 1'b0;
		// data moves on the falling link edge: 80 ns link period
		for (int i = 0; i <= n; i++) begin
			link_data_out = (i == 0) ? cmd : pl[8*(n-i) +: 8];
			#40 link_clock_out = 1'b1;
			#40 link_clock_out = 1'b0;
		end
		#40 link_select_n_out = 1'b1;
		link_data_out = ~link_data_out;
		// gap of more than two link periods before the next frame
		#200;
	endtask
endmodule // link_host_model

/* File: sim/flash_sector_protection_tb_top.sv */
// self-checking bench of the sector guard block
`timescale 1ns/1ps
`include "flash_guard_map.svh"
module flash_sector_protection_tb_top;
	// ==========================================
	// signals
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in, hard_reset_n_in;
	logic [7:0] awaddr_in, araddr_in, link_data_in;
	logic [31:0] wdata_in, rdata_out, d;
	logic [3:0] wstrb_in, array_sector_in;
	logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
	logic link_clock_in, link_select_n_in, array_write_allowed_out;
	logic [1:0] bresp_out, rresp_out, r;
	int miscompares = 0;
	int compares = 0;
	always #2 clock_in = ~clock_in;
	// ==========================================
	// design and far side
	flash_sector_protection u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
		.awvalid_in(awvalid_in), .awready_out(awready_out), .awaddr_in(awaddr_in),
		.wvalid_in(wvalid_in), .wready_out(wready_out), .wdata_in(wdata_in),
		.wstrb_in(wstrb_in), .bvalid_out(bvalid_out), .bready_in(bready_in),
		.bresp_out(bresp_out), .arvalid_in(arvalid_in), .arready_out(arready_out),
		.araddr_in(araddr_in), .rvalid_out(rvalid_out), .rready_in(rready_in),
		.rdata_out(rdata_out), .rresp_out(rresp_out), .link_clock_in(link_clock_in),
		.link_select_n_in(link_select_n_in), .link_data_in(link_data_in),
		.hard_reset_n_in(hard_reset_n_in), .array_sector_in(array_sector_in),
		.array_write_allowed_out(array_write_allowed_out));
	link_host_model u_host (.link_clock_out(link_clock_in),
		.link_select_n_out(link_select_n_in), .link_data_out(link_data_in));
	// ==========================================
	// helpers
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// bready held from the start, so the answer edge is also the release edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge clock_in);
		awaddr_in <= a;
		wdata_in <= v;
		awvalid_in <= 1'b1;
		wvalid_in <= 1'b1;
		bready_in <= 1'b1;
		// no wait limit here: only the watchdog ends a stuck transfer
		do begin
			@(posedge clock_in);
			if (awready_out) awvalid_in <= 1'b0;
			if (wready_out) wvalid_in <= 1'b0;
		end while (!bvalid_out);
		rs = bresp_out;
		bready_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clock_in);
		araddr_in <= a;
		arvalid_in <= 1'b1;
		rready_in <= 1'b1;
		do begin
			@(posedge clock_in);
			if (arready_out) arvalid_in <= 1'b0;
		end while (!rvalid_out);
		v = rdata_out;
		rs = rresp_out;
		rready_in <= 1'b0;
	endtask
	task automatic lnk(input logic [7:0] c, input logic [63:0] pl, input int n);
		u_host.send(c, pl, n);
		@(posedge clock_in);
	endtask
	// poll busy; status stays readable during the algorithm
	task automatic idle;
		int n;
		n = 0;
		do begin
			rd(`REG_STATUS, d, r);
			n++;
		end while (d[0] !== 1'b0 && n < 1000);
		chk(n < 1000, 1'b1);
	endtask
	task automatic otp(input logic [8:0] i, input logic [15:0] e);
		wr(`REG_OTP_ADDR, {23'h0, i}, r);
		rd(`REG_OTP_DATA, d, r);
		chk(d[15:0], e);
	endtask
	task automatic hrst;
		hard_reset_n_in <= 1'b0;
		repeat (8) @(posedge clock_in);
		hard_reset_n_in <= 1'b1;
		repeat (8) @(posedge clock_in);
	endtask
	task automatic test_done;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset;
		rd(`REG_PCW, d, r);
		chk(d[15:0], 16'hffff);
		chk(r, `RESP_OKAY);
		rd(`REG_NV_GUARD, d, r);
		chk(d[15:0], 16'hffff);
		rd(`REG_STATUS, d, r);
		chk(d[3], 1'b1);
		rd(`REG_PW_LO, d, r);
		chk(d, 32'h0);
		rd(8'h40, d, r);
		chk(r, `RESP_SLVERR);
		wr(8'h44, 32'h0, r);
		chk(r, `RESP_SLVERR);
		otp(9'h000, 16'(`OTP_RANDOM));
		otp(9'h007, 16'(`OTP_RANDOM >> 112));
		otp(9'h009, 16'hffff);
		$display("test reset done");
	endtask
	task automatic t_vol;
		lnk(`CMD_VOL_SET, 64'h3, 1);
		rd(`REG_VOL_GUARD, d, r);
		chk(d[15:0], 16'hfff7);
		array_sector_in <= 4'h3;
		repeat (2) @(posedge clock_in);
		chk(array_write_allowed_out, 1'b0);
		array_sector_in <= 4'h4;
		repeat (2) @(posedge clock_in);
		chk(array_write_allowed_out, 1'b1);
		lnk(`CMD_VOL_CLEAR, 64'h3, 1);
		rd(`REG_VOL_GUARD, d, r);
		chk(d[15:0], 16'hffff);
		$display("test volatile done");
	endtask
	task automatic t_nv;
		lnk(`CMD_GUARD_ENTER, 64'h0, 0);
		lnk(`CMD_NV_PROGRAM, 64'h5, 1);
		idle();
		chk(d[2:1], 2'b00);
		rd(`REG_NV_GUARD, d, r);
		chk(d[15:0], 16'hffdf);
		lnk(`CMD_VOL_CLEAR, 64'h5, 1);
		array_sector_in <= 4'h5;
		repeat (2) @(posedge clock_in);
		chk(array_write_allowed_out, 1'b0);
		lnk(`CMD_NV_READ, 64'h5, 1);
		rd(`REG_STATUS, d, r);
		chk(d[6], 1'b0);
		lnk(`CMD_NV_READ, 64'h6, 1);
		rd(`REG_STATUS, d, r);
		chk(d[6], 1'b1);
		lnk(`CMD_NV_ERASE, 64'h0, 0);
		idle();
		rd(`REG_NV_GUARD, d, r);
		chk(d[15:0], 16'hffff);
		lnk(`CMD_OVL_EXIT, 64'h0, 0);
		$display("test nonvolatile done");
	endtask
	task automatic t_lock;
		lnk(`CMD_LOCK_CLEAR, 64'h0, 0);
		lnk(`CMD_GUARD_ENTER, 64'h0, 0);
		lnk(`CMD_NV_PROGRAM, 64'h2, 1);
		idle();
		chk(d[3:1], 3'b001);
		lnk(`CMD_NV_ERASE, 64'h0, 0);
		idle();
		chk(d[2], 1'b1);
		rd(`REG_NV_GUARD, d, r);
		chk(d[15:0], 16'hffff);
		// default password matches, yet with the mode still open (not password) it must not relock
		lnk(`CMD_PW_UNLOCK, 64'hffff_ffff_ffff_ffff, 8);
		lnk(`CMD_SOFT_RESET, 64'h0, 0);
		rd(`REG_STATUS, d, r);
		chk(d[5:1], 5'b00000);
		lnk(`CMD_VOL_SET, 64'h1, 1);
		hrst();
		rd(`REG_STATUS, d, r);
		chk(d[3], 1'b1);
		rd(`REG_VOL_GUARD, d, r);
		chk(d[15:0], 16'hffff);
		$display("test lock done");
	endtask
	task automatic t_otp;
		lnk(`CMD_PROGRAM, {16'h0012, 16'h1234}, 4);
		otp(9'h012, 16'hffff);
		lnk(`CMD_OTP_ENTER, 64'h0, 0);
		lnk(`CMD_PROGRAM, {16'h0212, 16'h1234}, 4);
		idle();
		otp(9'h012, 16'h1234);
		lnk(`CMD_PROGRAM, {16'h0012, 16'h1234}, 4);
		idle();
		chk(d[1], 1'b0);
		lnk(`CMD_PROGRAM, {16'h0008, 16'hfffd}, 4);
		idle();
		otp(9'h008, 16'hfffd);
		lnk(`CMD_PROGRAM, {16'h0013, 16'h0000}, 4);
		idle();
		chk(d[1], 1'b1);
		otp(9'h013, 16'hffff);
		wr(`REG_STATUS, 32'h2, r);
		wr(`REG_VCW, 32'hfbff, r);
		lnk(`CMD_PROGRAM, {16'h0030, 16'h0000}, 4);
		idle();
		chk(d[1], 1'b0);
		otp(9'h030, 16'hffff);
		lnk(`CMD_OVL_EXIT, 64'h0, 0);
		rd(`REG_STATUS, d, r);
		chk(d[5:4], 2'b00);
		$display("test secure done");
	endtask
	task automatic t_pw;
		wr(`REG_PW_LO, 32'h1122_3344, r);
		chk(r, `RESP_OKAY);
		wr(`REG_PW_HI, 32'h5566_7788, r);
		wr(`REG_PCW, 32'hfffb, r);
		wr(`REG_PCW, 32'hffff, r);
		rd(`REG_PCW, d, r);
		chk(d[2:1], `MODE_PASS);
		hrst();
		rd(`REG_STATUS, d, r);
		chk(d[3], 1'b0);
		lnk(`CMD_PW_UNLOCK, 64'h5566_7788_1122_3345, 8);
		rd(`REG_STATUS, d, r);
		chk(d[3], 1'b0);
		lnk(`CMD_PW_UNLOCK, 64'h5566_7788_1122_3344, 8);
		rd(`REG_STATUS, d, r);
		chk(d[3], 1'b1);
		lnk(`CMD_LOCK_CLEAR, 64'h0, 0);
		rd(`REG_STATUS, d, r);
		chk(d[3], 1'b0);
		$display("test password done");
	endtask
	// ==========================================
	// main sequence and watchdog
	initial begin
		{awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 5'h00;
		{awaddr_in, araddr_in, wdata_in} = 48'h0;
		wstrb_in = 4'hf;
		array_sector_in = 4'h0;
		hard_reset_n_in = 1'b1;
		repeat (4) @(posedge clock_in);
		reset_n_in <= 1'b1;
		t_reset();
		t_vol();
		t_nv();
		t_lock();
		t_otp();
		t_pw();
		test_done();
	end
	initial begin
		// about eight times the expected run, well under the cycle budget
		#200000;
		miscompares++;
		test_done();
	end
endmodule // flash_sector_protection_tb_top
